// [pkg/adc_ctrl_pkg.sv]
// constants and types for the converter control registers
package adc_ctrl_pkg;
   // ==========================================
   // register offsets
   localparam logic [11:0] OFS_RESULT_LOW = 12'h000;
   localparam logic [11:0] OFS_RESULT_HIGH = 12'h004;
   localparam logic [11:0] OFS_START_CHAN = 12'h008;
   localparam logic [11:0] OFS_SRC_CLK = 12'h00c;
   localparam logic [11:0] OFS_REF = 12'h010;
   localparam logic [11:0] OFS_IRQ_STATUS = 12'h014;
   localparam logic [11:0] OFS_IRQ_MASK = 12'h018;
   // ==========================================
   // field positions
   localparam int START_BIT = 7;
   localparam int BUSY_BIT = 6;
   localparam int ENABLE_BIT = 5;
   localparam int ALIGN_BIT = 4;
   localparam int GAIN_BIT = 7;
   localparam int BANDGAP_BIT = 6;
   // ==========================================
   // reset values
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [11:0] RESULT_RESET = 12'h000;
   localparam logic [1:0] IRQ_RESET = 2'h0;
   // ==========================================
   // input source codes
   localparam logic [2:0] SRC_EXT_A = 3'h0;
   localparam logic [2:0] SRC_EXT_B = 3'h4;
   // ==========================================
   // interrupt bit positions
   localparam int IRQ_DONE = 0;
   localparam int IRQ_START = 1;
   // ==========================================
   // types
   typedef enum logic [1:0] {
      IDLE = 2'b00,
      CONVERT = 2'b01,
      FINISH = 2'b11
   } conv_state_t;
   typedef struct packed {
      logic start;
      logic enable;
      logic align;
      logic [2:0] chan;
   } start_chan_t;
   typedef struct packed {
      logic [2:0] source;
      logic [2:0] clkSel;
   } src_clk_t;
   typedef struct packed {
      logic gainEn;
      logic bandgapEn;
      logic [3:0] refSel;
   } ref_ctrl_t;
   typedef struct packed {
      logic extEn;
      logic [2:0] extChan;
      logic [2:0] intSel;
      logic sample;
      logic powerOn;
      logic clkEn;
   } core_ctrl_t;
endpackage : adc_ctrl_pkg

// [sim/adc_core_model.sv]
// behavioural converter core answering sample pulses
`timescale 1ns/100ps
`default_nettype none
module adc_core_model
   import adc_ctrl_pkg::*;
#(
   parameter int LAT = 6
)
(
   // control in
   input wire logic clk,
   input wire logic resetn,
   input wire core_ctrl_t coreCtrl,
   input wire logic [11:0] nextData,
   // result out
   output logic convDone,
   output logic [11:0] convData
);
   // ==========================================
   // conversion timed in conversion clock ticks
   int cnt;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cnt <= 0;
         convDone <= 1'b0;
         convData <= 12'h000;
      end else begin
         convDone <= 1'b0;
         convData <= ~convData; // stale data toggles
         if (coreCtrl.sample) begin
            cnt <= LAT;
         end else if (cnt > 0 && coreCtrl.clkEn) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
               convDone <= 1'b1;
               convData <= nextData;
            end
         end
         if (!coreCtrl.powerOn) begin
            cnt <= 0;
         end
      end
   end
endmodule : adc_core_model
`default_nettype wire

// [sim/adc_ctrl_monitor.sv]
// port checker for the converter control registers
`timescale 1ns/100ps
`default_nettype none
module adc_ctrl_monitor
   import adc_ctrl_pkg::*;
(
   // watched ports
   input wire logic clk,
   input wire logic resetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire core_ctrl_t coreCtrl,
   input wire ref_ctrl_t refCtrl,
   input wire logic irq
);
   // ==========================================
   // shadow of written fields
   logic acc;
   logic go;
   logic en_q;
   logic [7:0] ref_q;
   logic [1:0] mask_q;
   assign acc = psel && penable && pwrite;
   assign go = acc && paddr == OFS_START_CHAN && !pwdata[7];
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         en_q <= 1'b0;
         ref_q <= 8'h00;
         mask_q <= 2'h0;
      end else if (acc) begin
         if (paddr == OFS_START_CHAN) en_q <= pwdata[5];
         if (paddr == OFS_REF) ref_q <= pwdata[7:0];
         if (paddr == OFS_IRQ_MASK) mask_q <= pwdata[1:0];
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_ready; psel && !penable |=> pready; endproperty
   a_ready: assert property (p_ready)
      else $error("no ready after setup");
   property p_err;
      psel && !penable && paddr[1:0] == 2'h0
         |=> pslverr == ($past(paddr) > OFS_IRQ_MASK);
   endproperty
   a_err: assert property (p_err)
      else $error("wrong slave error");
   property p_pulse; coreCtrl.sample |=> !coreCtrl.sample; endproperty
   a_pulse: assert property (p_pulse)
      else $error("sample longer than one cycle");
   property p_cause; coreCtrl.sample |-> $past(go) || $past(go, 2); endproperty
   a_cause: assert property (p_cause)
      else $error("sample without start clear");
   property p_intern; coreCtrl.intSel != 3'h0 |-> !coreCtrl.extEn; endproperty
   a_intern: assert property (p_intern)
      else $error("external path on with internal source");
   property p_power; en_q == $past(en_q) |-> coreCtrl.powerOn == en_q; endproperty
   a_power: assert property (p_power)
      else $error("power differs from enable");
   property p_ref;
      ref_q == $past(ref_q) |-> refCtrl == {ref_q[7:6], ref_q[3:0]};
   endproperty
   a_ref: assert property (p_ref)
      else $error("reference outputs differ");
   property p_irq; mask_q == 2'h0 && $past(mask_q) == 2'h0 |-> !irq; endproperty
   a_irq: assert property (p_irq) // masked interrupt
      else $error("irq while all masked");
endmodule : adc_ctrl_monitor
`default_nettype wire

// [sim/tb.sv]
// testbench for the converter control registers
`timescale 1ns/100ps
`default_nettype none
module tb;
   import adc_ctrl_pkg::*;
   // ==========================================
   // signals and tables
   typedef struct packed {
      logic [7:0] c;
      logic [11:0] d;
      logic [7:0] h;
      logic [7:0] l;
   } row_t;
   row_t rows[4] = '{'{8'h20, 12'habc, 8'hab, 8'hc0},
      '{8'h30, 12'habc, 8'h0a, 8'hbc}, '{8'h27, 12'hfff, 8'hff, 8'hf0},
      '{8'h31, 12'h001, 8'h00, 8'h01}};
   logic [11:0] fa[3] = '{OFS_START_CHAN, OFS_SRC_CLK, OFS_REF};
   logic [7:0] fe[3] = '{8'hb7, 8'he7, 8'hcf};
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, ext;
   logic [11:0] paddr = 12'h000, nextData = 12'h000, convData;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic pready, pslverr, convDone, irq;
   core_ctrl_t coreCtrl;
   ref_ctrl_t refCtrl;
   int num_errors = 0, tests_run = 0, cyc = 0, ticks;
   always #10 clk = ~clk;
   adc_control_registers adc_control_registers_i (.clk(clk),
      .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .convDone(convDone), .convData(convData),
      .coreCtrl(coreCtrl), .refCtrl(refCtrl), .irq(irq));
   adc_core_model adc_core_model_i (.clk(clk), .resetn(resetn),
      .coreCtrl(coreCtrl), .nextData(nextData), .convDone(convDone),
      .convData(convData));
   // ==========================================
   // tasks
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic chk(input string n, input logic [31:0] e, g);
      tests_run++;
      if (g !== e) begin
         num_errors++;
         $display("mismatch %s exp %h got %h", n, e, g);
      end
   endtask : chk
   task automatic conv(input logic [7:0] c);
      apb(1, OFS_START_CHAN, {24'h0, c | 8'h80});
      apb(1, OFS_START_CHAN, {24'h0, c});
   endtask : conv
   task automatic idle;
      for (int i = 0; i < 40; i++) begin
         apb(0, OFS_START_CHAN, 0);
         if (rd[6] === 1'b0) break;
      end
   endtask : idle
   task automatic conclude;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : conclude
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         conclude();
      end
   end
   // ==========================================
   // sequence
   initial begin
      repeat (20) @(posedge clk);
      resetn <= 1'b1;
      apb(0, OFS_START_CHAN, 0);
      chk("reset", 0, rd);
      for (int i = 0; i < 4; i++) begin
         nextData <= rows[i].d;
         conv(rows[i].c);
         apb(0, OFS_START_CHAN, 0);
         chk("busy", 1, rd[6]);
         chk("chan", rows[i].c[2:0], coreCtrl.extChan);
         idle();
         chk("ctl", rows[i].c, rd);
         apb(0, OFS_RESULT_HIGH, 0);
         chk("high", rows[i].h, rd);
         apb(0, OFS_RESULT_LOW, 0);
         chk("low", rows[i].l, rd);
      end
      nextData <= 12'h555;
      apb(1, OFS_START_CHAN, 32'h10);
      conv(8'h10);
      repeat (20) @(posedge clk);
      chk("power", 0, coreCtrl.powerOn);
      apb(0, OFS_RESULT_LOW, 0);
      chk("kept", 8'h01, rd);
      for (int i = 0; i < 3; i++) begin
         apb(1, fa[i], 32'hff);
         apb(0, fa[i], 0);
         chk("field", fe[i], rd);
      end
      apb(1, 12'h01c, 32'hff);
      chk("slverr", 1, err);
      apb(0, 12'h01c, 0);
      chk("unmapped", 0, rd);
      apb(1, OFS_START_CHAN, 32'h25);
      for (int s = 0; s < 8; s++) begin
         apb(1, OFS_SRC_CLK, s << 5);
         repeat (2) @(posedge clk);
         ext = (s == 0 || s == 4);
         chk("extEn", ext, coreCtrl.extEn);
         chk("intSel", ext ? 0 : s, coreCtrl.intSel);
      end
      for (int k = 0; k < 8; k++) begin
         apb(1, OFS_SRC_CLK, k);
         repeat (128) @(posedge clk);
         ticks = 0;
         repeat (128) begin
            @(posedge clk);
            if (coreCtrl.clkEn === 1'b1) ticks++;
         end
         chk("ticks", 128 >> k, ticks);
      end
      apb(1, OFS_SRC_CLK, 0);
      apb(1, OFS_IRQ_STATUS, 3);
      apb(1, OFS_IRQ_MASK, 1);
      conv(8'h20);
      idle();
      repeat (2) @(posedge clk);
      chk("irq", 1, irq);
      apb(1, OFS_IRQ_MASK, 0);
      repeat (2) @(posedge clk);
      chk("masked", 0, irq);
      apb(0, OFS_IRQ_STATUS, 0);
      chk("status", 1, rd[0]);
      apb(1, OFS_IRQ_STATUS, 1);
      apb(1, OFS_IRQ_MASK, 1);
      repeat (2) @(posedge clk);
      chk("cleared", 0, irq);
      conclude();
   end
endmodule : tb
bind adc_control_registers adc_ctrl_monitor adc_ctrl_monitor_i (
   .clk(clk), .resetn(resetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
   .pslverr(pslverr), .coreCtrl(coreCtrl), .refCtrl(refCtrl), .irq(irq));
`default_nettype wire

// [verilog/adc_control_registers.sv]
// converter control registers behind an apb slave
`timescale 1ns/100ps
`default_nettype none
module adc_control_registers
   import adc_ctrl_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // converter core
   input wire logic convDone,
   input wire logic [11:0] convData,
   output core_ctrl_t coreCtrl,
   output ref_ctrl_t refCtrl,
   // interrupt
   output logic irq
);
   // ==========================================
   // register state
   start_chan_t sc_q;
   src_clk_t srcClk_q;
   ref_ctrl_t ref_q;
   logic [11:0] result_q;
   logic busy_q;
   logic [1:0] irqStat_q;
   logic [1:0] irqMask_q;
   logic [6:0] divCnt_q;
   logic divTick;
   conv_state_t state_q;
   logic wrEn;
   logic rdEn;
   logic mapped;
   logic startSeq;
   logic [7:0] wByte;
   logic [7:0] resLow;
   logic [7:0] resHigh;
   logic extSel;

   assign wByte = pwdata[7:0];
   assign wrEn = psel && penable && pwrite;
   assign rdEn = psel && penable && !pwrite;
   always_comb begin
      unique case (paddr)
         OFS_RESULT_LOW, OFS_RESULT_HIGH, OFS_START_CHAN, OFS_SRC_CLK,
         OFS_REF, OFS_IRQ_STATUS, OFS_IRQ_MASK: mapped = 1'b1;
         default: mapped = 1'b0;
      endcase
   end
   // start completes on write of low after high
   assign startSeq = wrEn && (paddr == OFS_START_CHAN) && sc_q.start
      && !wByte[START_BIT] && sc_q.enable;

   // ==========================================
   // control registers
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         sc_q <= start_chan_t'(CTRL_RESET[5:0]);
      end else if (wrEn && paddr == OFS_START_CHAN) begin
         sc_q.start <= wByte[START_BIT];
         sc_q.enable <= wByte[ENABLE_BIT];
         sc_q.align <= wByte[ALIGN_BIT];
         sc_q.chan <= wByte[2:0];
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         srcClk_q <= src_clk_t'(CTRL_RESET[5:0]);
      end else if (wrEn && paddr == OFS_SRC_CLK) begin
         srcClk_q.source <= wByte[7:5];
         srcClk_q.clkSel <= wByte[2:0];
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ref_q <= ref_ctrl_t'(CTRL_RESET[5:0]);
      end else if (wrEn && paddr == OFS_REF) begin
         ref_q.gainEn <= wByte[GAIN_BIT];
         ref_q.bandgapEn <= wByte[BANDGAP_BIT];
         ref_q.refSel <= wByte[3:0];
      end
   end

   // ==========================================
   // conversion clock divider
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         divCnt_q <= 7'h00;
      end else if (!sc_q.enable) begin
         divCnt_q <= 7'h00;
      end else begin
         divCnt_q <= divCnt_q + 7'h01;
      end
   end
   always_comb begin
      divTick = 1'b1;
      for (int i = 0; i < 7; i++) begin
         if (i < int'(srcClk_q.clkSel)) begin
            divTick = divTick && divCnt_q[i];
         end
      end
   end

   // ==========================================
   // conversion sequence
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= IDLE;
      end else if (!sc_q.enable) begin
         state_q <= IDLE;
      end else begin
         unique case (state_q)
            IDLE: if (startSeq) begin
               state_q <= CONVERT;
            end
            CONVERT: if (convDone) begin
               state_q <= FINISH;
            end
            FINISH: state_q <= IDLE;
         endcase
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         busy_q <= 1'b0;
      end else if (!sc_q.enable) begin
         busy_q <= 1'b0;
      end else if (state_q == IDLE && startSeq) begin
         busy_q <= 1'b1;
      end else if (state_q == CONVERT && convDone) begin
         busy_q <= 1'b0;
      end
   end
   // result captured only at completion while enabled
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         result_q <= RESULT_RESET;
      end else if (sc_q.enable && state_q == CONVERT && convDone) begin
         result_q <= convData;
      end
   end

   // ==========================================
   // core controls
   assign extSel = (srcClk_q.source == SRC_EXT_A)
      || (srcClk_q.source == SRC_EXT_B);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         coreCtrl <= '0;
         refCtrl <= '0;
      end else begin
         coreCtrl.extEn <= extSel && sc_q.enable;
         coreCtrl.extChan <= sc_q.chan;
         coreCtrl.intSel <= extSel ? 3'h0 : srcClk_q.source;
         coreCtrl.sample <= state_q == IDLE && startSeq;
         coreCtrl.powerOn <= sc_q.enable;
         coreCtrl.clkEn <= sc_q.enable && divTick;
         refCtrl <= ref_q;
      end
   end

   // ==========================================
   // interrupts
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irqStat_q <= IRQ_RESET;
      end else begin
         for (int i = 0; i < 2; i++) begin
            if (wrEn && paddr == OFS_IRQ_STATUS && wByte[i]) begin
               irqStat_q[i] <= 1'b0;
            end
         end
         if (state_q == CONVERT && convDone && sc_q.enable) begin
            irqStat_q[IRQ_DONE] <= 1'b1;
         end
         if (state_q == IDLE && startSeq) begin
            irqStat_q[IRQ_START] <= 1'b1;
         end
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irqMask_q <= IRQ_RESET;
      end else if (wrEn && paddr == OFS_IRQ_MASK) begin
         irqMask_q <= wByte[1:0];
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(irqStat_q & irqMask_q);
      end
   end

   // ==========================================
   // read path
   always_comb begin
      if (sc_q.align) begin
         resHigh = {4'h0, result_q[11:8]};
         resLow = result_q[7:0];
      end else begin
         resHigh = result_q[11:4];
         resLow = {result_q[3:0], 4'h0};
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         unique case (paddr)
            OFS_RESULT_LOW: prdata <= {24'h0, resLow};
            OFS_RESULT_HIGH: prdata <= {24'h0, resHigh};
            OFS_START_CHAN: prdata <= {24'h0, sc_q.start, busy_q,
               sc_q.enable, sc_q.align, 1'b0, sc_q.chan};
            OFS_SRC_CLK: prdata <= {24'h0, srcClk_q.source, 2'b00,
               srcClk_q.clkSel};
            OFS_REF: prdata <= {24'h0, ref_q.gainEn, ref_q.bandgapEn,
               2'b00, ref_q.refSel};
            OFS_IRQ_STATUS: prdata <= {30'h0, irqStat_q};
            OFS_IRQ_MASK: prdata <= {30'h0, irqMask_q};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= psel && !penable;
         pslverr <= psel && !penable && !mapped;
      end
   end
   logic unusedRd;
   assign unusedRd = rdEn;
endmodule : adc_control_registers
`default_nettype wire
